/* core/psra_device.sv */
`timescale 1ns/1ps
`include "psra_regs.svh"
module psra_device
    import psra_pkg::*;
(
    // clock and reset
    input  wire logic         sys_clk,
    input  wire logic         sys_rst,
    // serial link
    psra_link_if.device       link,
    // access to register owner
    output logic              accValid,
    output logic              accRead,
    output psra_target_e      accTarget,
    output logic              accChanB,
    output logic [11:0]       accAddr,
    output logic [7:0]        accData,
    // read byte, one cycle after a read access
    input  wire logic [7:0]   rdData,
    // page state
    output psra_apage_e       analogPage,
    output logic [23:0]       pageWindow
);
    localparam int NB = `PSRA_FRAME_BITS;

    // pin synchronisers, third stage is edge history
    logic [2:0]  clkSync_reg;
    logic [2:0]  enSync_reg;
    logic [1:0]  dinSync_reg;
    logic [4:0]  bitCnt_reg;
    logic [23:0] shiftIn_reg;
    logic        readFrame_reg;
    logic        hdrEvt_reg;
    logic [1:0]  waitRd_reg;
    logic [7:0]  outByte_reg;
    logic        sdo_reg;
    logic [7:0]  winLo_reg;
    logic [7:0]  winMid_reg;
    logic [7:0]  winHi_reg;
    logic [7:0]  conv_reg;
    logic [7:0]  mast_reg;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            clkSync_reg <= 3'h0;
            enSync_reg  <= 3'h7;
            dinSync_reg <= 2'h0;
        end else begin
            clkSync_reg <= {clkSync_reg[1:0], link.shiftClk};
            enSync_reg  <= {enSync_reg[1:0], link.frameEnableN};
            dinSync_reg <= {dinSync_reg[0], link.serialInLine};
        end
    end

    // edges and frame state
    wire frameOn = ~enSync_reg[1];                  // see R1
    wire clkRise = clkSync_reg[1] & ~clkSync_reg[2];
    wire clkFall = ~clkSync_reg[1] & clkSync_reg[2];
    wire enRise  = enSync_reg[1] & ~enSync_reg[2];
    wire stepIn  = clkRise & frameOn & (bitCnt_reg < 5'(NB)); // see R2
    wire hdrNow  = stepIn & (bitCnt_reg == 5'(`PSRA_HDR_BITS - 1));
    wire full    = bitCnt_reg == 5'(NB);
    wire commit  = enRise & full & ~readFrame_reg;  // see R4

    // frame view: header alone after 16 bits, whole word after 24
    wire [23:0] fv = full ? shiftIn_reg : {shiftIn_reg[15:0], 8'h00};
    wire        isRead = fv[`PSRA_BIT_RW];         // see R5
    wire        isDig  = fv[`PSRA_BIT_BANK];       // see R6
    wire        isReg  = fv[`PSRA_BIT_PR];         // see R7
    wire        side   = fv[`PSRA_BIT_SIDE];
    wire [11:0] addr   = fv[`PSRA_ADDR_HI:`PSRA_ADDR_LO];
    wire [7:0]  din    = fv[7:0];

    // direct pages: digital bank, page access, side flag set
    wire isDirect = isDig & ~isReg & side;          // see R17
    wire hitWinLo = addr == `PSRA_ADR_WIN_LO;
    wire hitWinMd = addr == `PSRA_ADR_WIN_MID;
    wire hitWinHi = addr == `PSRA_ADR_WIN_HI;
    wire hitConv  = addr == `PSRA_ADR_CONV;
    wire hitMast  = addr == `PSRA_ADR_MAST;
    wire hitAny   = hitWinLo | hitWinMd | hitWinHi | hitConv | hitMast;
    wire isGen    = ~isReg & ~isDirect & hitAny;    // see R13

    // digital page from the 24-bit window
    wire [23:0] win = {winHi_reg, winMid_reg, winLo_reg};
    wire [15:0] winKey = {win[23:16], win[7:0]};
    wire        winChB = win[15:8] == `PSRA_WIN_MID_B;
    wire        winMidOk = (win[15:8] == 8'h00) | winChB;
    wire        pgOff  = winMidOk & (winKey == `PSRA_WIN_OFF);  // see R14
    wire        pgGain = winMidOk & (winKey == `PSRA_WIN_GAIN);
    wire        pgMain = winMidOk & (winKey == `PSRA_WIN_MAIN);
    wire        pgLink = (win[15:8] == 8'h00) & (winKey == `PSRA_WIN_LINK);

    psra_target_e digTgt;
    psra_target_e anaTgt;
    psra_target_e tgt;
    logic         tgtChB;

    // selected digital page target
    always_comb begin
        digTgt = TGT_NONE;
        if (pgOff) begin
            digTgt = TGT_OFF;
        end else if (pgGain) begin
            digTgt = TGT_GAIN;
        end else if (pgMain) begin
            digTgt = TGT_MAIN;
        end else if (pgLink) begin
            digTgt = TGT_LINK;
        end
    end

    // selected analog page target
    always_comb begin
        case (analogPage)
            APG_MAST: anaTgt = TGT_MAST;
            APG_CONV: anaTgt = TGT_CONV;
            default:  anaTgt = TGT_NONE;
        endcase
    end

    // route the frame to a target and channel
    always_comb begin
        tgt    = TGT_NONE;
        tgtChB = 1'b0;
        if (isDirect) begin
            tgt    = addr[`PSRA_A_PAGE] ? TGT_PDET : TGT_DEC; // see R17, R18
            tgtChB = addr[`PSRA_A_CHAN];
        end else if (!isDig) begin
            tgt = anaTgt;                            // see R6, R12
        end else if (isReg) begin
            tgt    = digTgt;                         // see R15, R16
            tgtChB = pgLink ? ~side : winChB;        // see R8
        end
    end

    // readback of locally held page registers
    wire [7:0] genByte = hitWinLo ? winLo_reg :
                         hitWinMd ? winMid_reg :
                         hitWinHi ? winHi_reg :
                         hitConv  ? conv_reg : mast_reg;

    // input shifter, msb first
    always_ff @(posedge sys_clk) begin
        if (sys_rst || !frameOn) begin
            bitCnt_reg  <= 5'h00;
            shiftIn_reg <= 24'h000000;
        end else if (stepIn) begin
            bitCnt_reg  <= bitCnt_reg + 5'h01;
            shiftIn_reg <= {shiftIn_reg[22:0], dinSync_reg[1]}; // see R21
        end
    end

    // header event, one cycle after the 16th bit lands
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            hdrEvt_reg <= 1'b0;
        end else begin
            hdrEvt_reg <= hdrNow;
        end
    end

    // read flag held for the rest of the frame
    always_ff @(posedge sys_clk) begin
        if (sys_rst || enRise) begin
            readFrame_reg <= 1'b0;
        end else if (hdrEvt_reg) begin
            readFrame_reg <= isRead;
        end
    end

    // page window and analog page registers, kept until rewritten
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            winLo_reg  <= 8'h00;
            winMid_reg <= 8'h00;
            winHi_reg  <= 8'h00;
            conv_reg   <= 8'h00;
            mast_reg   <= 8'h00;
            analogPage <= APG_NONE;
        end else if (commit && isGen) begin     // see R11
            if (hitWinLo) winLo_reg  <= din;    // see R13
            if (hitWinMd) winMid_reg <= din;
            if (hitWinHi) winHi_reg  <= din;
            if (hitConv) conv_reg    <= din;
            if (hitMast) mast_reg    <= din;
            if (hitMast && din == `PSRA_VAL_MAST) begin
                analogPage <= APG_MAST;         // see R10
            end else if (hitConv && din == `PSRA_VAL_CONV) begin
                analogPage <= APG_CONV;         // see R10
            end
        end
    end

    // access reports: reads after the header, writes at frame end
    wire reportRd = hdrEvt_reg & isRead & ~isGen;
    wire reportWr = commit & ~isGen;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            accValid  <= 1'b0;
            accRead   <= 1'b0;
            accTarget <= TGT_NONE;
            accChanB  <= 1'b0;
            accAddr   <= 12'h000;
            accData   <= 8'h00;
        end else begin
            accValid <= reportRd | reportWr;
            if (reportRd || reportWr) begin
                accRead   <= reportRd;
                accTarget <= tgt;
                accChanB  <= tgtChB;
                accAddr   <= addr;
                accData   <= reportRd ? 8'h00 : din;
            end
        end
    end

    // owner answers in the cycle after its access pulse, so take it one later
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            waitRd_reg <= 2'h0;
        end else begin
            waitRd_reg <= {waitRd_reg[0], reportRd};
        end
    end

    // output byte on the eight falls that follow rises 16 to 23 of a read frame
    wire driveOut = clkFall & frameOn & readFrame_reg &
                    (bitCnt_reg >= 5'(`PSRA_HDR_BITS)) & ~full; // see R22

    always_ff @(posedge sys_clk) begin
        if (sys_rst || !frameOn) begin
            outByte_reg <= 8'h00;
            sdo_reg     <= 1'b0;
        end else if (hdrEvt_reg && isRead && isGen) begin
            outByte_reg <= genByte;             // see R12
        end else if (waitRd_reg[1]) begin
            outByte_reg <= rdData;              // see R16
        end else if (driveOut) begin
            sdo_reg     <= outByte_reg[7];      // see R9
            outByte_reg <= {outByte_reg[6:0], 1'b0};
        end
    end

    assign link.serialOutLine = sdo_reg;
    assign pageWindow = win;
endmodule // psra_device

/* core/psra_regs.svh */
`ifndef PSRA_REGS_SVH
`define PSRA_REGS_SVH
// Contract
// R1 - shift only while frame enable low
// R2 - sample input line on shift rises
// R3 - host shift clock at most 20 MHz
// R4 - frame is exactly 24 bits
// R5 - flags: read, bank, page/reg, side
// R6 - bank 0 analog, 1 digital
// R7 - digital: 0 page access, 1 register
// R8 - link page side 0 B, 1 A
// R9 - output changes on falls, host samples rises
// R10 - analog pages via 0012h/04h, 0011h/ffh
// R11 - selected page stays selected
// R12 - analog read: select page, read flag
// R13 - window in 002h-004h, three frames
// R14 - window decodes to seven digital pages
// R15 - digital register write uses bank+page/reg
// R16 - digital read with three flags set
// R17 - direct page by bank+side, A10, A11
// R18 - 5001h write reaches decimation page A
// R19 - host keeps sampling clock running
// R20 - host keeps side flag 0 paging
// R21 - frame shifted msb first
// R22 - read byte on last eight periods
`define PSRA_FRAME_BITS  24
`define PSRA_HDR_BITS    16
`define PSRA_BIT_RW      23
`define PSRA_BIT_BANK    22
`define PSRA_BIT_PR      21
`define PSRA_BIT_SIDE    20
`define PSRA_ADDR_HI     19
`define PSRA_ADDR_LO     8
`define PSRA_A_PAGE      10
`define PSRA_A_CHAN      11
`define PSRA_ADR_WIN_LO  12'h002
`define PSRA_ADR_WIN_MID 12'h003
`define PSRA_ADR_WIN_HI  12'h004
`define PSRA_ADR_CONV    12'h011
`define PSRA_ADR_MAST    12'h012
`define PSRA_VAL_MAST    8'h04
`define PSRA_VAL_CONV    8'hff
`define PSRA_WIN_OFF     16'h6100
`define PSRA_WIN_GAIN    16'h6105
`define PSRA_WIN_MAIN    16'h6800
`define PSRA_WIN_LINK    16'h6900
`define PSRA_WIN_MID_B   8'h01
`define PSRA_SYS_NS      10
`define PSRA_SCLK_NS     160
`define PSRA_HALF_CYC    ((`PSRA_SCLK_NS / `PSRA_SYS_NS) / 2)
`endif

/* core/psra_pkg.sv */
package psra_pkg;
    typedef enum logic [8:0] {
        TGT_NONE = 9'h001,
        TGT_MAST = 9'h002,
        TGT_CONV = 9'h004,
        TGT_OFF  = 9'h008,
        TGT_GAIN = 9'h010,
        TGT_MAIN = 9'h020,
        TGT_LINK = 9'h040,
        TGT_DEC  = 9'h080,
        TGT_PDET = 9'h100
    } psra_target_e;
    typedef enum logic [2:0] {
        APG_NONE = 3'h1,
        APG_MAST = 3'h2,
        APG_CONV = 3'h4
    } psra_apage_e;
    typedef enum logic [5:0] {
        HS_IDLE = 6'h01,
        HS_LEAD = 6'h02,
        HS_HIGH = 6'h04,
        HS_LOW  = 6'h08,
        HS_TAIL = 6'h10,
        HS_GAP  = 6'h20
    } psra_hstate_e;
endpackage

/* core/psra_link_if.sv */
`timescale 1ns/1ps
interface psra_link_if;
    logic frameEnableN;
    logic shiftClk;
    logic serialInLine;
    logic serialOutLine;
    modport device (
        input  frameEnableN,
        input  shiftClk,
        input  serialInLine,
        output serialOutLine
    );
    modport host (
        output frameEnableN,
        output shiftClk,
        output serialInLine,
        input  serialOutLine
    );
endinterface // psra_link_if

/* core/psra_host.sv */
`timescale 1ns/1ps
`include "psra_regs.svh"
module psra_host
    import psra_pkg::*;
#(
    parameter int HALF_CYC = `PSRA_HALF_CYC
)(
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    // serial link
    psra_link_if.host        link,
    // command side
    input  wire logic        cmdValid,
    input  wire logic [23:0] cmdWord,
    output logic             cmdReady,
    // read response
    output logic             rspValid,
    output logic [7:0]       rspData
);
    localparam int NB = `PSRA_FRAME_BITS;

    psra_hstate_e state_reg;
    logic [7:0]   div_reg;
    logic [4:0]   bitCnt_reg;
    logic [23:0]  word_reg;
    logic [7:0]   rx_reg;
    logic [1:0]   soSync_reg;
    logic         enN_reg;
    logic         clk_reg;
    logic         sdi_reg;
    logic         cmdWordRead_reg;

    // readback line synchroniser
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            soSync_reg <= 2'h0;
        end else begin
            soSync_reg <= {soSync_reg[0], link.serialOutLine};
        end
    end

    // half period of the shift clock elapsed
    wire halfDone = div_reg == 8'(HALF_CYC - 1);    // see R3
    wire lastBit  = bitCnt_reg == 5'(NB - 1);
    wire capture  = bitCnt_reg >= 5'(`PSRA_HDR_BITS); // readback lags a fall ~6 cycles, keep HALF_CYC >= 6

    // frame sequencer
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state_reg  <= HS_IDLE;
            div_reg    <= 8'h00;
            bitCnt_reg <= 5'h00;
            word_reg   <= 24'h000000;
            rx_reg     <= 8'h00;
            enN_reg    <= 1'b1;
            clk_reg    <= 1'b0;
            sdi_reg    <= 1'b0;
            cmdReady   <= 1'b1;
            rspValid   <= 1'b0;
            rspData    <= 8'h00;
        end else begin
            rspValid <= 1'b0;
            div_reg  <= halfDone ? 8'h00 : div_reg + 8'h01;
            case (state_reg)
                HS_IDLE: begin
                    div_reg <= 8'h00;
                    if (cmdValid) begin
                        word_reg   <= cmdWord;
                        sdi_reg    <= cmdWord[`PSRA_BIT_RW]; // see R21
                        enN_reg    <= 1'b0;                  // see R1
                        bitCnt_reg <= 5'h00;
                        cmdReady   <= 1'b0;
                        state_reg  <= HS_LEAD;
                    end
                end
                HS_LEAD: begin
                    if (halfDone) begin
                        clk_reg   <= 1'b1;
                        state_reg <= HS_HIGH;
                    end
                end
                HS_HIGH: begin
                    if (halfDone) begin
                        clk_reg    <= 1'b0;
                        bitCnt_reg <= bitCnt_reg + 5'h01;
                        word_reg   <= {word_reg[22:0], 1'b0};
                        sdi_reg    <= word_reg[22];
                        state_reg  <= lastBit ? HS_TAIL : HS_LOW;
                    end
                end
                HS_LOW: begin
                    if (halfDone) begin
                        clk_reg   <= 1'b1;
                        state_reg <= HS_HIGH;
                        if (capture) begin
                            rx_reg <= {rx_reg[6:0], soSync_reg[1]}; // see R9, R22
                        end
                    end
                end
                HS_TAIL: begin
                    if (halfDone) begin
                        enN_reg   <= 1'b1;                  // see R4
                        sdi_reg   <= 1'b0;
                        state_reg <= HS_GAP;
                    end
                end
                HS_GAP: begin
                    if (halfDone) begin
                        cmdReady  <= 1'b1;
                        rspValid  <= ~cmdWordRead_reg;
                        rspData   <= rx_reg;                // see R12, R16
                        state_reg <= HS_IDLE;
                    end
                end
                default: begin
                    state_reg <= HS_IDLE;
                    enN_reg   <= 1'b1;
                    clk_reg   <= 1'b0;
                    cmdReady  <= 1'b1;
                end
            endcase
        end
    end

    // read flag of the frame in flight, inverted so reset means none
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            cmdWordRead_reg <= 1'b1;
        end else if (state_reg == HS_IDLE && cmdValid) begin
            cmdWordRead_reg <= ~cmdWord[`PSRA_BIT_RW];
        end
    end

    assign link.frameEnableN = enN_reg;
    assign link.shiftClk     = clk_reg;
    assign link.serialInLine = sdi_reg;
endmodule // psra_host

/* sim/psra_link_props.sv */
`timescale 1ns/1ps
module psra_link_props #(
    parameter int HALF_CYC = 4
)(
    // clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // link wires
    input wire logic frameEnableN,
    input wire logic shiftClk,
    input wire logic serialInLine,
    input wire logic serialOutLine
);
    default clocking linkCb @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);

    logic       clkDly;
    logic [4:0] bitCnt;
    int         hiCnt;
    int         loCnt;
    wire        clkRise = shiftClk && !clkDly;

    // bit count per frame and length of each clock phase
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            clkDly <= 1'b0;
            bitCnt <= 5'h00;
            hiCnt  <= 0;
            loCnt  <= 0;
        end else begin
            clkDly <= shiftClk;
            bitCnt <= frameEnableN ? 5'h00 : bitCnt + 5'(clkRise);
            hiCnt  <= shiftClk ? hiCnt + 1 : 0;
            loCnt  <= (!shiftClk && !frameEnableN) ? loCnt + 1 : 0;
        end
    end

    AST_CLK_IDLE_OUTSIDE: assert property (frameEnableN |-> !shiftClk)
        else $error("shift clock high outside a frame");
    AST_DATA_STABLE_HIGH: assert property (shiftClk && clkDly |-> $stable(serialInLine))
        else $error("input line moved while shift clock high");
    AST_HIGH_PHASE: assert property ($fell(shiftClk) |-> hiCnt == HALF_CYC)
        else $error("shift clock high phase has wrong length");
    AST_LOW_PHASE: assert property ($rose(shiftClk) |-> loCnt == HALF_CYC)
        else $error("shift clock low phase has wrong length");
    AST_FRAME_24: assert property ($rose(frameEnableN) |-> bitCnt == 5'h18)
        else $error("frame closed with a bit count other than 24");
    AST_ENABLE_GAP: assert property ($rose(frameEnableN) |-> frameEnableN[*4])
        else $error("frames closer than the enable gap");
    AST_OUT_ON_FALLS: assert property (!frameEnableN && $changed(serialOutLine) |-> !shiftClk)
        else $error("output line changed while shift clock high");
    AST_OUT_IDLE: assert property (frameEnableN[*8] |-> !serialOutLine)
        else $error("output line not quiet between frames");
    AST_OUT_HEADER: assert property (!frameEnableN && bitCnt < 5'h10 |-> !serialOutLine)
        else $error("output line driven during the header");
endmodule // psra_link_props

/* sim/paged_serial_register_access_test.sv */
`timescale 1ns/1ps
module paged_serial_register_access_test;
    import psra_pkg::*;
    localparam int HALF = 8; // 160 ns link clock period
    logic         sys_clk;
    logic         sys_rst;
    logic         cmdValid;
    logic [23:0]  cmdWord;
    logic         cmdReady;
    logic         rspValid;
    logic [7:0]   rspData;
    logic         accValid;
    logic         accRead;
    logic         accChanB;
    psra_target_e accTarget;
    logic [11:0]  accAddr;
    logic [7:0]   accData;
    logic [7:0]   rdData;
    psra_apage_e  analogPage;
    logic [23:0]  pageWindow;
    logic         rawValid;
    logic [11:0]  rawAddr;
    int           failures;
    int           compares;
    int           accCnt;
    int           rspCnt;
    int           rawCnt;
    logic         prevClk;
    logic [23:0]  wireIn;
    logic [7:0]   wireOut;
    logic [21:0]  seenAcc;
    psra_target_e seenTgt;
    logic [7:0]   seenRsp;
    logic [23:0]  expWin;
    psra_apage_e  expPage;
    logic [31:0]  r;
    logic [23:0]  winTab [7] = '{24'h610000, 24'h610100, 24'h610005, 24'h610105, 24'h680000, 24'h680100, 24'h690000};

    psra_link_if link();
    psra_link_if rawLink();

    psra_host #(.HALF_CYC(HALF)) psra_host_i (.sys_clk(sys_clk), .sys_rst(sys_rst), .link(link.host),
        .cmdValid(cmdValid), .cmdWord(cmdWord), .cmdReady(cmdReady), .rspValid(rspValid), .rspData(rspData));
    psra_device psra_device_i (.sys_clk(sys_clk), .sys_rst(sys_rst), .link(link.device), .accValid(accValid),
        .accRead(accRead), .accTarget(accTarget), .accChanB(accChanB), .accAddr(accAddr), .accData(accData),
        .rdData(rdData), .analogPage(analogPage), .pageWindow(pageWindow));
    psra_device raw_psra_device_i (.sys_clk(sys_clk), .sys_rst(sys_rst), .link(rawLink.device),
        .accValid(rawValid), .accRead(), .accTarget(), .accChanB(), .accAddr(rawAddr), .accData(),
        .rdData(8'h00), .analogPage(), .pageWindow());
    psra_link_props #(.HALF_CYC(HALF)) psra_link_props_i (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .frameEnableN(link.frameEnableN), .shiftClk(link.shiftClk), .serialInLine(link.serialInLine),
        .serialOutLine(link.serialOutLine));

    // system clock
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    function automatic logic [7:0] ownerByte(input logic [11:0] a);
        return a[7:0] ^ {a[11:8], 4'h5};
    endfunction

    // wire monitor, output capture and register owner
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            {prevClk, wireIn, wireOut, seenAcc, seenRsp, rdData} <= '0;
            {accCnt, rspCnt, rawCnt} <= '0;
            seenTgt <= TGT_NONE;
        end else begin
            prevClk <= link.shiftClk;
            if (!link.frameEnableN && link.shiftClk && !prevClk) begin
                wireIn  <= {wireIn[22:0], link.serialInLine};
                wireOut <= {wireOut[6:0], link.serialOutLine};
            end
            if (accValid) begin
                accCnt  <= accCnt + 1;
                seenAcc <= {accRead, accChanB, accAddr, accData};
                seenTgt <= accTarget;
            end
            if (rspValid) begin
                rspCnt  <= rspCnt + 1;
                seenRsp <= rspData;
            end
            if (rawValid) rawCnt <= rawCnt + 1;
            rdData <= (accValid && accRead) ? ownerByte(accAddr) : 8'($urandom);
        end
    end

    task automatic print_verdict();
        if (failures == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic waitReady();
        int n;
        n = 0;
        while (cmdReady !== 1'b1 && n < 2000) begin
            @(posedge sys_clk);
            n++;
        end
        if (n >= 2000) begin
            failures++;
            print_verdict();
        end
    endtask

    // one frame through the host, then predict and compare
    task automatic frame(input logic [23:0] w);
        int           a0;
        int           r0;
        logic         hit;
        logic         cb;
        logic [7:0]   rb;
        psra_target_e tg;
        a0  = accCnt;
        r0  = rspCnt;
        hit = 1'b1;
        cb  = 1'b0;
        rb  = ownerByte(w[19:8]);
        tg  = TGT_NONE;
        waitReady();
        cmdValid <= 1'b1;
        cmdWord  <= w;
        @(posedge sys_clk);
        cmdValid <= 1'b0;
        @(posedge sys_clk);
        waitReady();
        repeat (8) @(posedge sys_clk);
        if (!w[22]) begin
            hit = !(!w[23] && (w[19:8] == 12'h011 || w[19:8] == 12'h012));
            tg  = (expPage == APG_MAST) ? TGT_MAST : (expPage == APG_CONV) ? TGT_CONV : TGT_NONE;
        end else if (!w[21] && w[20]) begin
            tg = w[18] ? TGT_PDET : TGT_DEC;
            cb = w[19];
        end else if (!w[21]) begin
            hit = 1'b0;
            rb  = w[8] ? expWin[15:8] : w[9] ? expWin[7:0] : expWin[23:16];
        end else begin
            cb = (expWin == 24'h690000) ? !w[20] : expWin[8];
            case ({expWin[23:16], expWin[7:0]})
                16'h6100: tg = TGT_OFF;
                16'h6105: tg = TGT_GAIN;
                16'h6800: tg = TGT_MAIN;
                16'h6900: tg = TGT_LINK;
                default:  tg = TGT_NONE;
            endcase
        end
        check(wireIn, w);
        check(accCnt - a0, hit);
        if (hit) begin
            check(seenTgt, tg);
            check(seenAcc, {w[23], cb, w[19:8], w[23] ? 8'h00 : w[7:0]});
        end
        if (w[23]) begin
            check(rspCnt - r0, 1);
            check(seenRsp, rb);
            check(wireOut, rb);
        end
        if (w[23:20] == 4'h0 && w[19:0] == 20'h01204) expPage = APG_MAST;
        if (w[23:20] == 4'h0 && w[19:0] == 20'h011ff) expPage = APG_CONV;
        if (w[23:20] == 4'h4 && w[19:8] == 12'h002) expWin[7:0] = w[7:0];
        if (w[23:20] == 4'h4 && w[19:8] == 12'h003) expWin[15:8] = w[7:0];
        if (w[23:20] == 4'h4 && w[19:8] == 12'h004) expWin[23:16] = w[7:0];
        check(pageWindow, expWin);
        check(analogPage, expPage);
    endtask

    // hand-driven frame on the second link, en low keeps the enable high
    task automatic rawFrame(input logic [23:0] w, input int n, input logic en);
        @(posedge sys_clk);
        rawLink.frameEnableN <= ~en;
        for (int i = 0; i < n; i++) begin
            rawLink.serialInLine <= w[23 - i];
            repeat (HALF) @(posedge sys_clk);
            rawLink.shiftClk <= 1'b1;
            repeat (HALF) @(posedge sys_clk);
            rawLink.shiftClk <= 1'b0;
        end
        repeat (HALF) @(posedge sys_clk);
        rawLink.frameEnableN <= 1'b1;
        rawLink.serialInLine <= ~w[0];
        repeat (8) @(posedge sys_clk);
    endtask

    // main sequence
    initial begin
        sys_rst = 1'b1;
        cmdValid = 1'b0;
        cmdWord = 24'h000000;
        rawLink.frameEnableN = 1'b1;
        rawLink.shiftClk = 1'b0;
        rawLink.serialInLine = 1'b0;
        expWin = 24'h000000;
        {failures, compares} = '0;
        expPage = APG_NONE;
        r = $urandom(32'hee67);
        repeat (3) @(posedge sys_clk);
        sys_rst <= 1'b0;
        frame(24'h000a33);
        foreach (winTab[i]) begin
            if (i < 2) begin
                frame(i == 0 ? 24'h001204 : 24'h0011ff);
                repeat (2) begin
                    r = $urandom;
                    frame({8'h01, r[15:0]});
                    frame({8'h81, r[23:8]});
                end
            end
            frame({16'h4004, winTab[i][23:16]});
            frame({16'h4003, winTab[i][15:8]});
            frame({16'h4002, winTab[i][7:0]});
            r = $urandom;
            frame({3'h3, r[20:0]});
            frame({3'h7, r[23:3]});
        end
        frame(24'hc00400);
        frame(24'hc00200);
        frame(24'h500102);
        for (int j = 0; j < 4; j++) begin
            r = $urandom;
            frame({4'h5, 2'(j), r[17:0]});
        end
        rawFrame(24'h5801a5, 24, 1'b0);
        check(rawCnt, 0);
        rawFrame(24'h5801a5, 16, 1'b1);
        check(rawCnt, 0);
        rawFrame(24'h5801a5, 24, 1'b1);
        check(rawCnt, 1);
        check(rawAddr, 12'h801);
        print_verdict();
    end
endmodule // paged_serial_register_access_test
